// ===== hw/qup_consts.vh
// Purpose: constants for the quad uart pin and host bus block
// Assumes: one clock, host strobes synchronous to clk_i
// Notes: offsets are register indexes on the 3-bit host address
// Summary of operation
// - writing one to modem_control_reg bit 0 drives that DTR pin low
// - DTR pin high after writing zero to the bit, and after reset
// - four channels, each with its own active-high interrupt output
// - select low: interrupt drivers on only while output-enable bit is one
// - interrupt raised only for sources enabled in intr_enable_reg
// - sources: line error, receive data, transmit space, modem status change
// - after reset, with select low, all four interrupt outputs are high impedance
// - select high: interrupt outputs always driven, enable bit ignored
// - select low: output-enable bit alone decides interrupt drive
// - read strobe falling edge drives addressed register onto data bus
// - write strobe rising edge stores data bus into addressed register
`ifndef QUP_CONSTS_VH
`define QUP_CONSTS_VH
`define QUP_NCHAN 4
`define QUP_ADDR_IER 3'h1
`define QUP_ADDR_ISR 3'h2
`define QUP_ADDR_MCR 3'h4
`define QUP_ADDR_SRC 3'h5
`define QUP_ADDR_SCR 3'h7
`define QUP_MCR_DTR 0
`define QUP_MCR_OE 3
`define QUP_IER_RXD 0
`define QUP_IER_TXE 1
`define QUP_IER_LSE 2
`define QUP_IER_MSC 3
`define QUP_RST_BYTE 8'h00
`define QUP_ISR_NONE 8'h01
`endif

// ===== hw/qup_regmem.v
// Purpose: per-channel register store with registered read data
// Assumes: one write and one read port, same clock
// Notes: holds ier, mcr and scratch for four channels
`timescale 1ns/1ps
`include "qup_consts.vh"
module qup_regmem
(
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // write port
   input wire wr_en_i,
   input wire [4:0] wr_addr_i,
   input wire [7:0] wr_data_i,
   // read port
   input wire [4:0] rd_addr_i,
   output reg [7:0] rd_data_o,
   // flat view of all words
   output wire [255:0] all_o
);
   reg [7:0] mem_reg [0:31];
   genvar g;
   integer i;
   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         for (i = 0; i < 32; i = i + 1)
            mem_reg[i] <= `QUP_RST_BYTE;
         rd_data_o <= `QUP_RST_BYTE;
      end
      else
      begin
         if (wr_en_i)
            mem_reg[wr_addr_i] <= wr_data_i;
         rd_data_o <= mem_reg[rd_addr_i];
      end
   end
   generate
      for (g = 0; g < 32; g = g + 1)
      begin : flat
         assign all_o[g*8 +: 8] = mem_reg[g];
      end
   endgenerate
endmodule // qup_regmem

// ===== hw/qup_top.v
// Purpose: quad uart DTR and interrupt pins plus host read/write strobes
// Assumes: host strobes and chip selects sampled synchronously on clk_i
// Notes: interrupt sources arrive as level inputs from the uart cores
`timescale 1ns/1ps
`include "qup_consts.vh"
module qup_top
(
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // host bus
   input wire [3:0] host_cs_n_i,
   input wire [2:0] host_addr_i,
   input wire host_read_strobe_n_i,
   input wire host_write_strobe_n_i,
   input wire [7:0] host_data_i,
   output reg [7:0] host_data_o,
   output reg host_data_oe_o,
   // interrupt select pin
   input wire irq_force_select_i,
   // interrupt sources per channel, one bit each
   input wire [3:0] src_rx_data_i,
   input wire [3:0] src_tx_space_i,
   input wire [3:0] src_line_err_i,
   input wire [3:0] src_modem_chg_i,
   // channel pins
   output reg [3:0] dtr_n_o,
   output reg [3:0] chan_irq_out_o,
   output reg [3:0] chan_irq_oe_o
);
   // ----------------------------------------
   // decode helpers
   // ----------------------------------------
   function [1:0] chan_of;
      input [3:0] cs_n;
      begin
         casez (cs_n)
            4'b???0: chan_of = 2'h0;
            4'b??01: chan_of = 2'h1;
            4'b?011: chan_of = 2'h2;
            default: chan_of = 2'h3;
         endcase
      end
   endfunction

   function [7:0] isr_code;
      input [7:0] intr_enable_reg;
      input ls;
      input rx;
      input tx;
      input ms;
      begin
         // fixed priority: line error, rx data, tx space, modem
         if (ls && intr_enable_reg[`QUP_IER_LSE])
            isr_code = 8'h06;
         else if (rx && intr_enable_reg[`QUP_IER_RXD])
            isr_code = 8'h04;
         else if (tx && intr_enable_reg[`QUP_IER_TXE])
            isr_code = 8'h02;
         else if (ms && intr_enable_reg[`QUP_IER_MSC])
            isr_code = 8'h00;
         else
            isr_code = `QUP_ISR_NONE;
      end
   endfunction

   // ----------------------------------------
   // strobe edge detection
   // ----------------------------------------
   reg rd_n_reg;
   reg wr_n_reg;
   wire sel_any = ~&host_cs_n_i;
   wire rd_fall = rd_n_reg & ~host_read_strobe_n_i & sel_any;
   wire wr_rise = ~wr_n_reg & host_write_strobe_n_i & sel_any;
   wire [1:0] chan = chan_of(host_cs_n_i);
   reg rd_pend_reg;
   reg [2:0] rd_addr_reg;
   reg [1:0] rd_chan_reg;

   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rd_n_reg <= 1'b1;
         wr_n_reg <= 1'b1;
         rd_pend_reg <= 1'b0;
         rd_addr_reg <= 3'h0;
         rd_chan_reg <= 2'h0;
      end
      else
      begin
         rd_n_reg <= host_read_strobe_n_i;
         wr_n_reg <= host_write_strobe_n_i;
         rd_pend_reg <= rd_fall;
         if (rd_fall)
         begin
            rd_addr_reg <= host_addr_i;
            rd_chan_reg <= chan;
         end
      end
   end

   // ----------------------------------------
   // register store
   // ----------------------------------------
   wire [7:0] mem_rd;
   wire [255:0] mem_all;
   qup_regmem u_mem
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_en_i(wr_rise),
      .wr_addr_i({chan, host_addr_i}),
      .wr_data_i(host_data_i),
      .rd_addr_i({chan, host_addr_i}),
      .rd_data_o(mem_rd),
      .all_o(mem_all)
   );

   // ----------------------------------------
   // per-channel pins
   // ----------------------------------------
   wire [7:0] isr_w [0:3];
   wire [3:0] irq_w;
   wire [3:0] dtr_n_next;
   wire [3:0] irq_oe_next;
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : ch
         wire [7:0] intr_enable_reg = mem_all[(g*8+`QUP_ADDR_IER)*8 +: 8];
         wire [7:0] modem_control_reg = mem_all[(g*8+`QUP_ADDR_MCR)*8 +: 8];
         assign isr_w[g] = isr_code(intr_enable_reg, src_line_err_i[g],
            src_rx_data_i[g], src_tx_space_i[g], src_modem_chg_i[g]);
         assign irq_w[g] = (src_line_err_i[g] & intr_enable_reg[`QUP_IER_LSE]) |
            (src_rx_data_i[g] & intr_enable_reg[`QUP_IER_RXD]) |
            (src_tx_space_i[g] & intr_enable_reg[`QUP_IER_TXE]) |
            (src_modem_chg_i[g] & intr_enable_reg[`QUP_IER_MSC]);
         assign dtr_n_next[g] = ~modem_control_reg[`QUP_MCR_DTR];
         // select forces drive; else enable bit rules
         assign irq_oe_next[g] = irq_force_select_i | modem_control_reg[`QUP_MCR_OE];
      end
   endgenerate

   // one process for all channels, so each pin vector has one driver
   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         dtr_n_o <= 4'hF;
         chan_irq_oe_o <= 4'h0;
         chan_irq_out_o <= 4'h0;
      end
      else
      begin
         dtr_n_o <= dtr_n_next;
         chan_irq_oe_o <= irq_oe_next;
         chan_irq_out_o <= irq_w;
      end
   end

   // ----------------------------------------
   // host read data
   // ----------------------------------------
   wire [7:0] rd_src = (rd_addr_reg == `QUP_ADDR_ISR) ? isr_w[rd_chan_reg] :
      (rd_addr_reg == `QUP_ADDR_SRC) ?
      {4'h0, src_modem_chg_i[rd_chan_reg], src_line_err_i[rd_chan_reg],
      src_tx_space_i[rd_chan_reg], src_rx_data_i[rd_chan_reg]} : mem_rd;

   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         host_data_o <= 8'h00;
         host_data_oe_o <= 1'b0;
      end
      else
      begin
         // load data after falling edge, hold while low
         if (rd_pend_reg)
            host_data_o <= rd_src;
         host_data_oe_o <= ~host_read_strobe_n_i & sel_any &
            (rd_pend_reg | host_data_oe_o);
      end
   end
endmodule // qup_top

// ===== sim/qup_monitor.sv
// Purpose: port checks on the host read path and interrupt pins
// Assumes: one clock, reset asynchronous and active high
// Notes: sees top ports only, attached by bind
`timescale 1ns/1ps
module qup_monitor
(
   input wire clk_i,
   input wire rst_i,
   input wire [3:0] host_cs_n_i,
   input wire host_read_strobe_n_i,
   input wire [7:0] host_data_o,
   input wire host_data_oe_o,
   input wire irq_force_select_i,
   input wire [3:0] src_rx_data_i,
   input wire [3:0] src_tx_space_i,
   input wire [3:0] src_line_err_i,
   input wire [3:0] src_modem_chg_i,
   input wire [3:0] chan_irq_out_o,
   input wire [3:0] chan_irq_oe_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence rd_take;
      $fell(host_read_strobe_n_i) && host_cs_n_i != 4'hF;
   endsequence
   sequence no_src;
      (src_rx_data_i | src_tx_space_i | src_line_err_i | src_modem_chg_i)
         == 4'h0;
   endsequence
   rd_answer_a: assert property (rd_take ##1 !host_read_strobe_n_i[*3]
      |-> host_data_oe_o) else $error("read data not driven");
   rd_release_a: assert property ($rose(host_read_strobe_n_i)
      |-> ##2 !host_data_oe_o) else $error("bus not released");
   idle_bus_a: assert property (host_read_strobe_n_i[*3]
      |-> !host_data_oe_o) else $error("bus driven while idle");
   no_cs_a: assert property ((!host_read_strobe_n_i &&
      host_cs_n_i == 4'hF)[*3] |-> !host_data_oe_o) else $error("unselected");
   data_hold_a: assert property ($fell(host_data_oe_o)
      |-> $stable(host_data_o)) else $error("data lost at release");
   read_stable_a: assert property (
      host_data_oe_o && $past(host_data_oe_o) |-> $stable(host_data_o))
      else $error("read data moved");
   irq_force_a: assert property (irq_force_select_i
      |=> chan_irq_oe_o == 4'hF) else $error("forced drive missing");
   irq_quiet_a: assert property (no_src ##1 no_src
      |-> chan_irq_out_o == 4'h0) else $error("interrupt without source");
endmodule // qup_monitor
bind qup_top qup_monitor mon (.clk_i(clk_i), .rst_i(rst_i),
   .host_cs_n_i(host_cs_n_i), .host_read_strobe_n_i(host_read_strobe_n_i),
   .host_data_o(host_data_o), .host_data_oe_o(host_data_oe_o),
   .irq_force_select_i(irq_force_select_i), .src_rx_data_i(src_rx_data_i),
   .src_tx_space_i(src_tx_space_i), .src_line_err_i(src_line_err_i),
   .src_modem_chg_i(src_modem_chg_i), .chan_irq_out_o(chan_irq_out_o),
   .chan_irq_oe_o(chan_irq_oe_o));

// ===== sim/qup_host_model.sv
// Purpose: controlling cpu on the 8-bit strobe bus
// Assumes: strobes move just after rising edges
// Notes: write data inverted once released, never left at last value
`timescale 1ns/1ps
module qup_host_model
(
   input wire clk_i,
   output reg [3:0] cs_n_o = 4'hF,
   output reg [2:0] addr_o = 3'h0,
   output reg rd_n_o = 1'b1,
   output reg wr_n_o = 1'b1,
   output reg [7:0] data_o = 8'h00,
   input wire [7:0] data_i,
   input wire oe_i
);
   task wr(input [1:0] ch, input [2:0] a, input [7:0] d);
   begin
      @(posedge clk_i);
      cs_n_o <= ~(4'h1 << ch);
      addr_o <= a;
      data_o <= d;
      wr_n_o <= 1'b0;
      @(posedge clk_i);
      wr_n_o <= 1'b1;
      @(posedge clk_i);
      cs_n_o <= 4'hF;
      data_o <= ~d;
   end
   endtask
   task rd(input [3:0] cs, input [2:0] a, output [7:0] d, output oe);
   begin
      @(posedge clk_i);
      cs_n_o <= cs;
      addr_o <= a;
      rd_n_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      // undriven bus has no pull, so never show a stale byte
      d = oe_i ? data_i : ~data_i;
      oe = oe_i;
      rd_n_o <= 1'b1;
      cs_n_o <= 4'hF;
      @(posedge clk_i);
   end
   endtask
endmodule // qup_host_model

// ===== sim/tb_top.sv
// Purpose: self-checking bench for qup_top
// Assumes: host model drives the bus, bench drives sources and select
// Notes: source bits packed rx, tx, line, modem per nibble
`timescale 1ns/1ps
module tb_top;
   reg clk_i = 1'b0;
   reg rst_i = 1'b1;
   reg irq_force_select_i = 1'b0;
   reg [15:0] src_reg = 16'h0000;
   reg [31:0] ident_reg = 32'h00060204;
   reg [7:0] d;
   reg oe;
   integer i;
   integer mismatches = 0;
   integer samples_checked = 0;
   wire [3:0] cs_n, dtr_n, irq, irq_oe;
   wire [2:0] addr;
   wire rd_n, wr_n, doe;
   wire [7:0] wdata, rdata;
   always #4 clk_i = ~clk_i;
   qup_host_model host (.clk_i(clk_i), .cs_n_o(cs_n), .addr_o(addr),
      .rd_n_o(rd_n), .wr_n_o(wr_n), .data_o(wdata), .data_i(rdata),
      .oe_i(doe));
   qup_top uut (.clk_i(clk_i), .rst_i(rst_i), .host_cs_n_i(cs_n),
      .host_addr_i(addr), .host_read_strobe_n_i(rd_n),
      .host_write_strobe_n_i(wr_n), .host_data_i(wdata),
      .host_data_o(rdata), .host_data_oe_o(doe),
      .irq_force_select_i(irq_force_select_i),
      .src_rx_data_i(src_reg[3:0]), .src_tx_space_i(src_reg[7:4]),
      .src_line_err_i(src_reg[11:8]), .src_modem_chg_i(src_reg[15:12]),
      .dtr_n_o(dtr_n), .chan_irq_out_o(irq), .chan_irq_oe_o(irq_oe));
   task check(input [63:0] name, input [7:0] seen, input [7:0] exp);
   begin
      samples_checked = samples_checked + 1;
      if (seen !== exp)
      begin
         mismatches = mismatches + 1;
         $display("unexpected %0s exp %h seen %h", name, exp, seen);
      end
   end
   endtask
   task print_verdict;
   begin
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   end
   endtask
   initial
   begin
      #20000;
      mismatches = mismatches + 1;
      print_verdict;
   end
   initial
   begin
      repeat (4) @(posedge clk_i);
      check("dtr", dtr_n, 4'hF);
      check("irqoe", irq_oe, 4'h0);
      check("rdoe", doe, 1'b0);
      rst_i <= 1'b0;
      host.wr(2'd2, 3'h4, 8'h01);
      @(posedge clk_i);
      #1 check("dtr", dtr_n, 4'hB);
      host.rd(4'hB, 3'h4, d, oe);
      check("mcr", d, 8'h01);
      check("rdoe", oe, 1'b1);
      repeat (2) @(posedge clk_i);
      #1 check("rdoe", doe, 1'b0);
      host.wr(2'd2, 3'h4, 8'h00);
      @(posedge clk_i);
      #1 check("dtr", dtr_n, 4'hF);
      host.rd(4'hF, 3'h4, d, oe);
      check("rdoe", oe, 1'b0);
      $display("test dtr and read done");
      host.wr(2'd1, 3'h1, 8'h0F);
      host.wr(2'd1, 3'h4, 8'h08);
      @(posedge clk_i);
      #1 check("irqoe", irq_oe, 4'h2);
      for (i = 0; i < 4; i = i + 1)
      begin
         @(posedge clk_i);
         src_reg <= 16'h3 << (4 * i);
         repeat (2) @(posedge clk_i);
         #1 check("irq", irq, 4'h2);
         host.rd(4'hD, 3'h2, d, oe);
         check("ident", d, ident_reg[8 * i +: 8]);
      end
      host.wr(2'd1, 3'h1, 8'h07);
      @(posedge clk_i);
      #1 check("irq", irq, 4'h0);
      host.rd(4'hD, 3'h2, d, oe);
      check("ident", d, 8'h01);
      host.rd(4'hD, 3'h5, d, oe);
      check("levels", d, 8'h08);
      $display("test sources done");
      @(posedge clk_i);
      irq_force_select_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      #1 check("irqoe", irq_oe, 4'hF);
      @(posedge clk_i);
      irq_force_select_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1 check("irqoe", irq_oe, 4'h2);
      host.wr(2'd1, 3'h4, 8'h00);
      @(posedge clk_i);
      #1 check("irqoe", irq_oe, 4'h0);
      $display("test drive select done");
      print_verdict;
   end
endmodule // tb_top
